// ### dmx_params.svh
// register offsets, field positions, reset values and timing counts of the dma engine
`ifndef DMX_PARAMS_SVH
`define DMX_PARAMS_SVH
`define DMX_NCH           6
`define DMX_OFF_SETCLR    16'h003E
`define DMX_OFF_PREC      16'h005E
`define DMX_OFF_SYNC      16'h005F
`define DMX_OFF_PAGE      16'h003D
`define DMX_OFF_CH_BASE   16'h0040
`define DMX_OFF_CH_END    16'h005D
`define DMX_CH_SRC        3'h0
`define DMX_CH_DST        3'h1
`define DMX_CH_CNT        3'h2
`define DMX_CH_MODE       3'h3
`define DMX_CH_IDX        3'h4
`define DMX_SC_SET_BIT    15
`define DMX_MD_IRQ_EN     14
`define DMX_MD_IRQ_HALF   13
`define DMX_MD_SRC_EXT    11
`define DMX_MD_DWORD      10
`define DMX_MD_SRC_IDX    9:8
`define DMX_MD_SRC_SPACE  7:6
`define DMX_MD_DST_EXT    5
`define DMX_MD_DST_IDX    3:2
`define DMX_MD_DST_SPACE  1:0
`define DMX_RST_MODE      16'h0000
`define DMX_RST_PREC      16'h0000
`define DMX_EXT_WR_CYC    4'd8
`define DMX_EXT_RD_CYC    4'd9
`define DMX_PROG_TOP      16'h7FFF
`endif

// ### dmx_pkg.sv
// types shared by the dma engine
package dmx_pkg;
  typedef enum logic [1:0] {DMX_IX_HOLD, DMX_IX_INC, DMX_IX_DEC, DMX_IX_ADD} dmx_index_t;
  typedef enum logic [1:0] {DMX_SP_PROG, DMX_SP_DATA, DMX_SP_IO, DMX_SP_RSVD} dmx_space_t;
  typedef enum logic [2:0] {DMX_IDLE, DMX_RD, DMX_RD_CAP, DMX_WR, DMX_DONE} dmx_state_t;
  typedef enum logic [1:0] {DMX_OWN_NONE, DMX_OWN_CPU, DMX_OWN_DMA} dmx_owner_t;
endpackage

// ### dmx_pick.sv
// round-robin picker among ready channels
`timescale 1ns/1ns
module dmx_pick (
  input  wire logic [5:0] req,
  input  wire logic [2:0] last,
  output logic            valid,
  output logic [2:0]      sel
);
  always_comb begin
    logic [2:0] c;
    valid = 1'b0;
    sel   = 3'd0;
    c     = 3'd0;
    for (int k = 1; k <= 6; k++) begin
      c = 3'((int'(last) + k) % 6);
      if (!valid && req[c]) begin
        valid = 1'b1;
        sel   = c;
      end
    end
  end
endmodule

// ### dmx_engine.sv
// six-channel dma engine with cpu register port, internal memory port and external bus
// Notes on behaviour
// - six channels, each with its own addresses, counts and mode
// - engine wins internal memory over the cpu in a shared cycle
// - source and destination step by hold, increment, decrement or index
// - a channel may wait for its own sync event per element
// - interrupt pulse on full block, or on both half and full block
// - double-word internal element moves as two 16-bit transfers
// - only one external-read and one external-write channel may run
// - external write lasts 8 cycles, external read 9 cycles
// - bus owner holds the bus; the other party waits
// - engine request beats cpu external request in the same cycle
// - external accesses are single 16-bit words, double-word ignored
// - mode bit 11 selects external source, bit 5 external destination
// - destination space 00 program, 01 data, 10 io, 11 reserved
// - extended page drives the bus only for engine accesses
// - cpu program address above on-chip range flags an external access
// - completion clears the channel run bit
// - set/clear write sets or clears selected run bits per bit 15
// - unselected channels keep their run bit on a set/clear write
// - set/clear register at 0x003E, write-only, reads zero
// - engine map ignores processor memory mode settings
`timescale 1ns/1ns
`include "dmx_params.svh"
module dmx_engine (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic [5:0]  sync_event,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [1:0]  mem_space,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  output logic             cpu_mem_hold,
  input  wire logic        cpu_ext_req,
  output logic             cpu_ext_grant,
  output logic             cpu_ext_wait,
  input  wire logic [15:0] cpu_prog_addr,
  output logic             cpu_prog_ext,
  output logic             ext_req,
  output logic             ext_we,
  output logic      [1:0]  ext_space,
  output logic      [6:0]  ext_page,
  output logic      [15:0] ext_addr,
  output logic      [15:0] ext_wdata,
  input  wire logic [15:0] ext_rdata,
  output logic      [5:0]  irq_half,
  output logic      [5:0]  irq_full
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] addr_step(input logic [15:0] a, input logic [1:0] m,
                                            input logic [15:0] ix);
    unique case (dmx_pkg::dmx_index_t'(m))
      dmx_pkg::DMX_IX_HOLD: addr_step = a;
      dmx_pkg::DMX_IX_INC:  addr_step = a + 16'h0001;
      dmx_pkg::DMX_IX_DEC:  addr_step = a - 16'h0001;
      dmx_pkg::DMX_IX_ADD:  addr_step = a + ix;
    endcase
  endfunction

  function automatic logic [5:0] first_set(input logic [5:0] v);
    first_set = v & (~v + 6'h01);
  endfunction

  function automatic logic in_slots(input logic [15:0] a);
    in_slots = a >= `DMX_OFF_CH_BASE && a <= `DMX_OFF_CH_END;
  endfunction

  // fixed map, no processor memory-mode inputs; five words per channel
  function automatic logic [5:0] slot_of(input logic [15:0] a);
    logic [4:0] o;
    o       = 5'(a - `DMX_OFF_CH_BASE);
    slot_of = {3'(o / 5'd5), 3'(o % 5'd5)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-channel contexts
  logic [15:0] src [6], next_src [6];
  logic [15:0] dst [6], next_dst [6];
  logic [15:0] cnt [6], next_cnt [6];
  logic [15:0] init [6], next_init [6];
  logic [15:0] mode [6], next_mode [6];
  logic [15:0] idx [6], next_idx [6];
  logic [5:0]  run, next_run;
  logic [9:0]  prec_hi, next_prec_hi;
  logic [5:0]  sync_en, next_sync_en;
  logic [6:0]  page, next_page;
  logic [5:0]  ev_s1, ev_s2, ev_d, ev_pend, next_ev_pend;
  dmx_pkg::dmx_state_t st, next_st;
  dmx_pkg::dmx_owner_t own, next_own;
  logic [2:0]  ch, next_ch;
  logic        dw_hi, next_dw_hi;
  logic [3:0]  ecnt, next_ecnt;
  logic [15:0] data, next_data;
  logic [15:0] next_reg_rdata;
  logic [5:0]  next_irq_half, next_irq_full;
  logic        next_mem_req, next_mem_we, next_ext_req, next_ext_we;
  logic        next_cpu_ext_grant, next_cpu_ext_wait, next_cpu_prog_ext;
  logic [5:0]  ready, rd_ext_ok, wr_ext_ok, sx, dx;
  logic        pick_valid;
  logic [2:0]  pick_sel;
  logic [15:0] md;
  logic        sel_ch;
  logic [2:0]  wch;
  logic [5:0]  slot;
  logic [1:0]  next_sp;
  logic [6:0]  next_pg;
  logic [15:0] next_ad;
  logic [110:0] outs, next_outs;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  assign slot = slot_of(reg_addr);

  dmx_pick u_pick (
    .req   (ready),
    .last  (ch),
    .valid (pick_valid),
    .sel   (pick_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      sx[i] = mode[i][`DMX_MD_SRC_EXT];
      dx[i] = mode[i][`DMX_MD_DST_EXT];
    end
    // first enabled external reader and writer only
    rd_ext_ok = first_set(run & sx);
    wr_ext_ok = first_set(run & dx);
    for (int i = 0; i < 6; i++) begin
      // synced channels wait for a pending event
      ready[i] = run[i] && (!sx[i] || rd_ext_ok[i]) && (!dx[i] || wr_ext_ok[i])
                 && (!sync_en[i] || ev_pend[i]);
    end
  end

  always_comb begin
    md           = mode[ch];
    sel_ch       = 1'b0;
    wch          = slot[5:3];
    next_src     = src;
    next_dst     = dst;
    next_cnt     = cnt;
    next_init    = init;
    next_mode    = mode;
    next_idx     = idx;
    next_run     = run;
    next_prec_hi = prec_hi;
    next_sync_en = sync_en;
    next_page    = page;
    next_st      = st;
    next_own     = own;
    next_ch      = ch;
    next_dw_hi   = dw_hi;
    next_ecnt    = ecnt;
    next_data    = data;
    next_irq_half = 6'h00;
    next_irq_full = 6'h00;
    // sync events latch; a new edge wins over the consume below
    next_ev_pend = ev_pend;
    unique case (st)
      dmx_pkg::DMX_IDLE: begin
        if (pick_valid) begin
          next_ch = pick_sel;
          next_st = dmx_pkg::DMX_RD;
          next_ev_pend[pick_sel] = 1'b0;
        end
      end
      dmx_pkg::DMX_RD: begin
        if (md[`DMX_MD_SRC_EXT]) begin
          // wait while the cpu owns the external bus
          if (own != dmx_pkg::DMX_OWN_CPU) begin
            next_own  = dmx_pkg::DMX_OWN_DMA;
            next_ecnt = (own == dmx_pkg::DMX_OWN_DMA) ? ecnt + 4'd1 : 4'd0;
            // read holds the bus nine cycles
            if (own == dmx_pkg::DMX_OWN_DMA && ecnt == `DMX_EXT_RD_CYC - 4'd1) begin
              next_data = ext_rdata;
              next_own  = dmx_pkg::DMX_OWN_NONE;
              next_st   = dmx_pkg::DMX_WR;
            end
          end
        end else begin
          next_st = dmx_pkg::DMX_RD_CAP;
        end
      end
      dmx_pkg::DMX_RD_CAP: begin
        next_data = mem_rdata;
        next_st   = dmx_pkg::DMX_WR;
      end
      dmx_pkg::DMX_WR: begin
        if (md[`DMX_MD_DST_EXT]) begin
          if (own != dmx_pkg::DMX_OWN_CPU) begin
            next_own  = dmx_pkg::DMX_OWN_DMA;
            next_ecnt = (own == dmx_pkg::DMX_OWN_DMA) ? ecnt + 4'd1 : 4'd0;
            // write holds the bus eight cycles
            if (own == dmx_pkg::DMX_OWN_DMA && ecnt == `DMX_EXT_WR_CYC - 4'd1) begin
              next_own = dmx_pkg::DMX_OWN_NONE;
              next_st  = dmx_pkg::DMX_DONE;
            end
          end
        end else begin
          next_st = dmx_pkg::DMX_DONE;
        end
      end
      dmx_pkg::DMX_DONE: begin
        // independent post-adjust of source and destination
        next_src[ch] = addr_step(src[ch], md[`DMX_MD_SRC_IDX], idx[ch]);
        next_dst[ch] = addr_step(dst[ch], md[`DMX_MD_DST_IDX], idx[ch]);
        // double word only when both ends are internal
        if (md[`DMX_MD_DWORD] && !md[`DMX_MD_SRC_EXT] && !md[`DMX_MD_DST_EXT] && !dw_hi) begin
          next_dw_hi = 1'b1;
          next_st    = dmx_pkg::DMX_RD;
        end else begin
          next_dw_hi  = 1'b0;
          next_st     = dmx_pkg::DMX_IDLE;
          next_cnt[ch] = cnt[ch] - 16'h0001;
          if (md[`DMX_MD_IRQ_EN] && md[`DMX_MD_IRQ_HALF] && cnt[ch] - 16'h0001 == init[ch] >> 1
              && cnt[ch] != 16'h0001)
            next_irq_half[ch] = 1'b1;
          if (cnt[ch] == 16'h0001) begin
            next_run[ch] = 1'b0;
            next_irq_full[ch] = md[`DMX_MD_IRQ_EN];
          end
        end
      end
      default: next_st = dmx_pkg::DMX_IDLE;
    endcase
    next_ev_pend = next_ev_pend | (ev_s2 & ~ev_d);
    // engine need beats a cpu request; cpu keeps bus until it lets go
    if (own == dmx_pkg::DMX_OWN_CPU && !cpu_ext_req)
      next_own = dmx_pkg::DMX_OWN_NONE;
    else if (own == dmx_pkg::DMX_OWN_NONE && next_own == dmx_pkg::DMX_OWN_NONE && cpu_ext_req
             && !(st == dmx_pkg::DMX_IDLE && pick_valid && (sx[pick_sel] || dx[pick_sel])))
      next_own = dmx_pkg::DMX_OWN_CPU;
    // cpu register writes
    if (reg_wr) begin
      if (reg_addr == `DMX_OFF_SETCLR) begin
        // only selected bits follow the write
        for (int i = 0; i < 6; i++)
          if (reg_wdata[i])
            next_run[i] = reg_wdata[`DMX_SC_SET_BIT];
      end else if (reg_addr == `DMX_OFF_PREC) begin
        next_run     = reg_wdata[5:0];
        next_prec_hi = reg_wdata[15:6];
      end else if (reg_addr == `DMX_OFF_SYNC) begin
        next_sync_en = reg_wdata[5:0];
      end else if (reg_addr == `DMX_OFF_PAGE) begin
        next_page = reg_wdata[6:0];
      end else if (in_slots(reg_addr)) begin
        sel_ch = 1'b1;
      end
    end
    if (sel_ch) begin
      unique case (slot[2:0])
        `DMX_CH_SRC:  next_src[wch] = reg_wdata;
        `DMX_CH_DST:  next_dst[wch] = reg_wdata;
        `DMX_CH_CNT: begin
          next_cnt[wch]  = reg_wdata;
          next_init[wch] = reg_wdata;
        end
        `DMX_CH_MODE: next_mode[wch] = reg_wdata;
        `DMX_CH_IDX:  next_idx[wch] = reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // engine access flagged so the cpu stalls on internal memory
    next_mem_req = (st == dmx_pkg::DMX_RD && !md[`DMX_MD_SRC_EXT])
                   || (st == dmx_pkg::DMX_WR && !md[`DMX_MD_DST_EXT]);
    next_mem_we  = st == dmx_pkg::DMX_WR;
    next_ext_req = next_own == dmx_pkg::DMX_OWN_DMA;
    next_ext_we  = st == dmx_pkg::DMX_WR;
    next_ad      = (st == dmx_pkg::DMX_WR) ? dst[ch] : src[ch];
    // space code passes straight from the mode field
    next_sp      = (st == dmx_pkg::DMX_WR) ? md[`DMX_MD_DST_SPACE] : md[`DMX_MD_SRC_SPACE];
    // extended page only shows on engine cycles
    next_pg      = next_ext_req ? page : 7'h00;
    next_cpu_ext_grant = next_own == dmx_pkg::DMX_OWN_CPU;
    next_cpu_ext_wait  = cpu_ext_req && next_own != dmx_pkg::DMX_OWN_CPU;
    // above the on-chip program range goes off chip
    next_cpu_prog_ext  = cpu_prog_addr > `DMX_PROG_TOP;
    // set/clear is write-only and reads back zero
    next_reg_rdata = 16'h0000;
    if (reg_addr == `DMX_OFF_PREC)
      next_reg_rdata = {prec_hi, run};
    else if (reg_addr == `DMX_OFF_SYNC)
      next_reg_rdata = {10'h000, sync_en};
    else if (reg_addr == `DMX_OFF_PAGE)
      next_reg_rdata = {9'h000, page};
    else if (in_slots(reg_addr))
      unique case (slot[2:0])
        `DMX_CH_SRC:  next_reg_rdata = src[slot[5:3]];
        `DMX_CH_DST:  next_reg_rdata = dst[slot[5:3]];
        `DMX_CH_CNT:  next_reg_rdata = cnt[slot[5:3]];
        `DMX_CH_MODE: next_reg_rdata = mode[slot[5:3]];
        `DMX_CH_IDX:  next_reg_rdata = idx[slot[5:3]];
        default: ;
      endcase
  end

  // every output is a flop bit; mem and ext share address, space and data
  assign next_outs = {next_mem_req, next_mem_we, next_sp, next_ad, data, next_mem_req,
                      next_cpu_ext_grant, next_cpu_ext_wait, next_cpu_prog_ext, next_ext_req,
                      next_ext_we, next_sp, next_pg, next_ad, data, next_irq_half,
                      next_irq_full, next_reg_rdata};
  assign {mem_req, mem_we, mem_space, mem_addr, mem_wdata, cpu_mem_hold, cpu_ext_grant,
          cpu_ext_wait, cpu_prog_ext, ext_req, ext_we, ext_space, ext_page, ext_addr,
          ext_wdata, irq_half, irq_full, reg_rdata} = outs;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    src     <= next_src;
    dst     <= next_dst;
    cnt     <= next_cnt;
    init    <= next_init;
    idx     <= next_idx;
    data    <= next_data;
    if (!rstn)
      mode <= '{default: `DMX_RST_MODE};
    else
      mode <= next_mode;
    outs    <= rstn ? next_outs : 111'h0;
    run     <= rstn ? next_run : 6'(`DMX_RST_PREC);
    prec_hi <= rstn ? next_prec_hi : 10'(`DMX_RST_PREC >> 6);
    sync_en <= rstn ? next_sync_en : 6'h00;
    page    <= rstn ? next_page : 7'h00;
    // two flops before the edge detect; events come from other pins
    ev_s1   <= rstn ? sync_event : 6'h00;
    ev_s2   <= rstn ? ev_s1 : 6'h00;
    ev_d    <= rstn ? ev_s2 : 6'h00;
    ev_pend <= rstn ? next_ev_pend : 6'h00;
    st      <= rstn ? next_st : dmx_pkg::DMX_IDLE;
    own     <= rstn ? next_own : dmx_pkg::DMX_OWN_NONE;
    ch      <= rstn ? next_ch : 3'h0;
    dw_hi   <= rstn ? next_dw_hi : 1'b0;
    ecnt    <= rstn ? next_ecnt : 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_setclr_sel: assert property (reg_wr && reg_addr == `DMX_OFF_SETCLR && reg_wdata[0]
    |=> run[0] == $past(reg_wdata[`DMX_SC_SET_BIT])) else $error("selected run bit wrong");
  a_setclr_keep: assert property (reg_wr && reg_addr == `DMX_OFF_SETCLR && !reg_wdata[0]
    && st != dmx_pkg::DMX_DONE |=> run[0] == $past(run[0])) else $error("unselected bit moved");
  a_done_clears: assert property (st == dmx_pkg::DMX_DONE && next_st == dmx_pkg::DMX_IDLE
    && cnt[ch] == 16'h0001 && !reg_wr |=> !run[ch]) else $error("run bit kept after done");
  a_ext_wr_len: assert property ($rose(ext_req) && ext_we
    |-> ext_req [*8] ##1 !ext_req) else $error("external write length wrong");
  a_ext_rd_len: assert property ($rose(ext_req) && !ext_we
    |-> ext_req [*8] ##1 ext_req ##1 !ext_req) else $error("external read length wrong");
  a_bus_owner: assert property (!(cpu_ext_grant && ext_req))
    else $error("external bus has two owners");
  a_prog_ext: assert property (cpu_prog_ext == ($past(cpu_prog_addr) > `DMX_PROG_TOP))
    else $error("program external flag wrong");
  a_irq_full: assert property (|irq_full |-> $past(st) == dmx_pkg::DMX_DONE)
    else $error("full interrupt outside completion");
  c_ext_read: cover property (ext_req && !ext_we);
  c_ext_write: cover property (ext_req && ext_we);
  c_cpu_grant: cover property (cpu_ext_grant);
  c_sync_start: cover property (st == dmx_pkg::DMX_RD && sync_en[ch]);
endmodule

// ### dmx_mem_model.sv
// behavioural memory seen by the engine on its internal and external sides
`timescale 1ns/1ns
module dmx_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic      [15:0] mem_rdata,
  input  wire logic        ext_req,
  input  wire logic [15:0] ext_addr,
  output logic      [15:0] ext_rdata
);
  logic [15:0] flip = 16'h5A5A;
  ////////////////////////////////////////////////////////////////////////////
  // idle buses toggle every cycle so a stale word never passes for data
  always @(posedge clk_sys) flip <= ~flip;
  assign mem_rdata = mem_req ? (mem_addr ^ 16'hC3C3) : flip;
  assign ext_rdata = ext_req ? (ext_addr ^ 16'h3C3C) : ~flip;
endmodule

// ### test_dmx_engine.sv
// self-checking bench for the six-channel dma engine
`timescale 1ns/1ns
`include "dmx_params.svh"
module test_dmx_engine;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        cpu_ext_req = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] cpu_prog_addr = 16'h0000;
  logic [5:0]  sync_event = 6'h00;
  logic [15:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, ext_addr, ext_wdata, ext_rdata;
  logic        mem_req, mem_we, cpu_mem_hold, cpu_ext_grant, cpu_ext_wait, cpu_prog_ext;
  logic        ext_req, ext_we;
  logic [1:0]  mem_space, ext_space;
  logic [6:0]  ext_page;
  logic [5:0]  irq_half, irq_full;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk_sys = ~clk_sys;
  dmx_engine i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_event(sync_event), .mem_req(mem_req),
    .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .cpu_mem_hold(cpu_mem_hold), .cpu_ext_req(cpu_ext_req),
    .cpu_ext_grant(cpu_ext_grant), .cpu_ext_wait(cpu_ext_wait), .cpu_prog_addr(cpu_prog_addr),
    .cpu_prog_ext(cpu_prog_ext), .ext_req(ext_req), .ext_we(ext_we), .ext_space(ext_space),
    .ext_page(ext_page), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .irq_half(irq_half), .irq_full(irq_full));
  dmx_mem_model i_mem (.clk_sys(clk_sys), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .ext_req(ext_req), .ext_addr(ext_addr), .ext_rdata(ext_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // whole run needs a few hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // channel slots assumed five words apart; only channels 0-3 are addressed
  function automatic logic [15:0] ca(input int c, input logic [2:0] k);
    return `DMX_OFF_CH_BASE + 16'(c * 5) + 16'(k);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
  task automatic run_is(input logic [3:0] e);
    logic [15:0] v;
    rd(`DMX_OFF_PREC, v);
    chk({12'h000, v[3:0]}, {12'h000, e}, "run bits");
  endtask
  task automatic wait_bus(input bit ext, input bit we);
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_sys);
      #1;
      if (ext ? (ext_req === 1'b1 && ext_we === we) : (mem_req === 1'b1 && mem_we === we))
        break;
    end
    chk(16'(k < 300), 16'h0001, "bus access");
  endtask
  task automatic load(input logic [15:0] s, input logic [15:0] d, input logic [15:0] m);
    wr(ca(0, `DMX_CH_SRC), s);
    wr(ca(0, `DMX_CH_DST), d);
    wr(ca(0, `DMX_CH_CNT), 16'h0001);
    wr(ca(0, `DMX_CH_MODE), m);
    wr(`DMX_OFF_SETCLR, 16'h8001);
  endtask
  task automatic t_sync;
    wr(`DMX_OFF_SYNC, 16'h0001);
    load(16'h0500, 16'h0600, 16'h0001);
    repeat (10) @(posedge clk_sys);
    #1 chk(16'(mem_req), 16'h0000, "sync hold"); // waits for event
    @(posedge clk_sys);
    sync_event <= 6'h01;
    wait_bus(1'b0, 1'b1);
    chk(mem_addr, 16'h0600, "sync dest"); // event starts element
    @(posedge clk_sys);
    sync_event <= 6'h00;
    wr(`DMX_OFF_SYNC, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_setclr;
    logic [15:0] v;
    rd(ca(0, `DMX_CH_MODE), v);
    chk(v, `DMX_RST_MODE, "mode reset"); // internal default
    run_is(4'b0000); // none running
    // long blocks so no channel finishes meanwhile
    for (int c = 0; c < 4; c++) wr(ca(c, `DMX_CH_CNT), 16'hFFFF);
    wr(`DMX_OFF_SETCLR, 16'h8005);
    run_is(4'b0101); // set selected
    wr(`DMX_OFF_SETCLR, 16'h8002);
    run_is(4'b0111); // set selected
    wr(`DMX_OFF_SETCLR, 16'h0001);
    run_is(4'b0110); // others kept
    wr(`DMX_OFF_SETCLR, 16'hFFC0);
    run_is(4'b0110); // none selected
    rd(`DMX_OFF_SETCLR, v);
    chk(v, 16'h0000, "setclr read"); // write-only
    wr(`DMX_OFF_SETCLR, 16'h000F);
    run_is(4'b0000); // clear selected
  endtask
  task automatic t_space;
    logic [15:0] v;
    for (int d = 0; d < 3; d++) begin
      load(16'h0100, 16'h0200 + 16'(d), 16'(d));
      wait_bus(1'b0, 1'b1);
      chk(16'(mem_space), 16'(d), "dest space"); // space codes
      chk(mem_addr, 16'h0200 + 16'(d), "dest addr"); // first address
      chk(mem_wdata, 16'h0100 ^ 16'hC3C3, "moved word"); // word from source address
      for (int k = 0; k < 40; k++) begin
        rd(`DMX_OFF_PREC, v);
        if (v[0] === 1'b0) break;
      end
      chk(16'(v[0]), 16'h0000, "done clears"); // run bit cleared
    end
  endtask
  task automatic t_ext;
    load(16'h1234, 16'h0300, 16'h0801);
    wait_bus(1'b1, 1'b0);
    chk(ext_addr, 16'h1234, "ext rd addr"); // external source
    @(posedge clk_sys);
    cpu_ext_req <= 1'b1;
    @(posedge clk_sys);
    #1 chk({14'h0, cpu_ext_grant, cpu_ext_wait}, 16'h0001, "cpu held"); // cpu waits
    wait_bus(1'b0, 1'b1);
    chk(mem_wdata, 16'h1234 ^ 16'h3C3C, "ext word"); // single word
    for (int k = 0; k < 50 && cpu_ext_grant !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(16'(cpu_ext_grant), 16'h0001, "cpu granted"); // bus handed back
    @(posedge clk_sys);
    cpu_ext_req <= 1'b0;
    load(16'h0400, 16'h5678, 16'h0021);
    wait_bus(1'b1, 1'b1);
    chk(ext_addr, 16'h5678, "ext wr addr"); // external dest
    chk(ext_wdata, 16'h0400 ^ 16'hC3C3, "ext wr data"); // single word
    chk(16'(ext_space), 16'h0001, "ext space"); // data space
  endtask
  task automatic t_prog;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      cpu_prog_addr <= `DMX_PROG_TOP + 16'(i);
      repeat (2) @(posedge clk_sys);
      #1 chk(16'(cpu_prog_ext), 16'(i), "prog ext"); // outside bound
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_setclr;
    t_space;
    t_ext;
    t_sync;
    t_prog;
    summarize;
  end
endmodule
